// >>> design/rcl_pkg.sv
// Constants for the reset-condition logic block.
// Assumes a 32-bit APB master on the system clock.
package rcl_pkg;
	// ********************
	// Register offsets
	// ********************
	localparam logic [7:0] RCL_CAUSE_OFS = 8'h00;
	localparam logic [7:0] RCL_VSEL_OFS = 8'h04;
	localparam logic [7:0] RCL_STAT_OFS = 8'h08;
	localparam logic [7:0] RCL_PDATA_OFS = 8'h0C;
	localparam logic [7:0] RCL_PDIR_OFS = 8'h10;
	localparam logic [7:0] RCL_PIN_OFS = 8'h14;
	localparam logic [7:0] RCL_CTRL_OFS = 8'h18;
	localparam logic [7:0] RCL_IRQS_OFS = 8'h1C;
	localparam logic [7:0] RCL_IRQM_OFS = 8'h20;
	localparam logic [7:0] RCL_CPU_OFS = 8'h24;
	// ********************
	// Field positions
	// ********************
	localparam int RCL_WCF_BIT = 0;
	localparam int RCL_VSF_BIT = 1;
	localparam int RCL_LVF_BIT = 2;
	localparam int RCL_PDF_BIT = 4;
	localparam int RCL_EXP_BIT = 5;
	localparam int RCL_IRQ_WDT = 0;
	localparam int RCL_IRQ_LV = 1;
	localparam int RCL_IRQ_VS = 2;
	// ********************
	// Reset values and valid select codes
	// ********************
	localparam logic [7:0] RCL_VSEL_POR = 8'h55;
	localparam logic [7:0] RCL_VSEL_C1 = 8'h33;
	localparam logic [7:0] RCL_VSEL_C2 = 8'h99;
	localparam logic [7:0] RCL_VSEL_C3 = 8'hAA;
	localparam logic [7:0] RCL_PORT_POR = 8'hFF;
	localparam logic [3:0] RCL_STK_TOP = 4'h0;
	// ********************
	// Sequencer states and reset cause codes
	// ********************
	typedef enum logic [3:0] {
		RCL_RUN = 4'b0001,
		RCL_REC = 4'b0010,
		RCL_HOLD = 4'b0100,
		RCL_REL = 4'b1000
	} rcl_state_t;
	typedef enum logic [2:0] {
		RCL_C_POR = 3'b001,
		RCL_C_WRUN = 3'b010,
		RCL_C_WSLP = 3'b100
	} rcl_cause_t;
endpackage

// >>> design/rcl_top.sv
// Reset-condition logic: cause flags, per-cause state, port data path.
// Assumes an APB master, a supply monitor and core sleep status inputs.
// Function
// - undefined voltage select code sets its fault flag and resets
// - voltage select fault flag clears only by software zero or power-on
// - watchdog expiry while running gives full reset and sets expiry flag
// - watchdog expiry asleep clears only pc and stack, sets both flags
// - expiry and powerdown flags follow the reset cause table
// - all interrupt sources disabled after power-on
// - all timers stopped after power-on
// - all pins are inputs after power-on
// - stack index points at top of stack after power-on
// - each register takes its own value per reset cause
// - port inputs are not latched, read directly from the pins
// - port output latch holds until software rewrites it or a running reset reloads all ones
// - port data and direction start as all ones
// - qualified supply drop sets low voltage flag, software clears
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module rcl_top
	import rcl_pkg::*;
#(
	parameter int WDT_W = 16,
	parameter int HOLD_CYC = 4
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Core status and events
	input wire logic sleep_i,
	input wire logic lv_drop_i,
	// Port pins
	input wire logic [7:0] pin_i,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_n_o,
	// Core state outputs
	output logic core_rst_o,
	output logic [7:0] pc_low_o,
	output logic [3:0] stack_index_o,
	output logic [7:0] int_en_o,
	output logic [3:0] timer_on_o,
	output logic irq_o
);
	logic [7:0] vsel_r;
	logic wcf_r, vsf_r, lvf_r, exp_r, pdf_r;
	logic [7:0] pdata_r, pdir_r;
	logic [WDT_W-1:0] wlimit_r;
	logic [2:0] irqs_r, irqm_r;
	rcl_state_t st_r;
	rcl_cause_t cause_r;
	logic [7:0] hold_r;
	logic wdt_exp, wdt_clr, wr_en, rd_en, vs_bad, lv_ev;
	logic by_wdt_r;
	logic [31:0] rd_nxt;
	logic hit_nxt;
	// ********************
	// APB decode
	// ********************
	assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
	assign rd_en = psel_i && !penable_i && !pwrite_i;
	assign vs_bad = (vsel_r != RCL_VSEL_POR) && (vsel_r != RCL_VSEL_C1) &&
		(vsel_r != RCL_VSEL_C2) && (vsel_r != RCL_VSEL_C3);
	assign lv_ev = lv_drop_i && !sleep_i;
	assign wdt_clr = (st_r != RCL_RUN) || srst_i;
	always_comb begin
		rd_nxt = 32'h0000_0000;
		hit_nxt = 1'b1;
		case (paddr_i)
			RCL_CAUSE_OFS: rd_nxt = {29'h0, lvf_r, vsf_r, wcf_r};
			RCL_VSEL_OFS: rd_nxt = {24'h0, vsel_r};
			RCL_STAT_OFS: rd_nxt = {26'h0, exp_r, pdf_r, 4'h0};
			RCL_PDATA_OFS: rd_nxt = {24'h0, pdata_r};
			RCL_PDIR_OFS: rd_nxt = {24'h0, pdir_r};
			RCL_PIN_OFS: rd_nxt = {24'h0, pin_i};
			RCL_CTRL_OFS: rd_nxt = {16'h0, int_en_o, 4'h0, timer_on_o};
			RCL_IRQS_OFS: rd_nxt = {29'h0, irqs_r};
			RCL_IRQM_OFS: rd_nxt = {29'h0, irqm_r};
			RCL_CPU_OFS: rd_nxt = {20'h0, stack_index_o, pc_low_o};
			default: hit_nxt = 1'b0;
		endcase
	end
	// No wait states: data registered in setup, ready in access
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !hit_nxt;
			if (rd_en) begin
				prdata_o <= rd_nxt;
			end
		end
	end
	// ********************
	// Watchdog counter
	// ********************
	rcl_wdt_cnt #(
		.WIDTH(WDT_W)
	) u_wdt (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.clr_i(wdt_clr),
		.limit_i(wlimit_r),
		.expire_o(wdt_exp)
	);
	// ********************
	// Reset sequencer
	// ********************
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			st_r <= RCL_REC;
			cause_r <= RCL_C_POR;
			by_wdt_r <= 1'b0;
			hold_r <= 8'h00;
			core_rst_o <= 1'b1;
		end else begin
			case (st_r)
				RCL_RUN: begin
					if (wdt_exp && sleep_i) begin
						cause_r <= RCL_C_WSLP;
						st_r <= RCL_REC;
					end else if (wdt_exp || vs_bad || lv_ev) begin
						cause_r <= RCL_C_WRUN;
						by_wdt_r <= wdt_exp;
						st_r <= RCL_REC;
						core_rst_o <= 1'b1;
					end
				end
				RCL_REC: begin
					hold_r <= 8'(HOLD_CYC);
					st_r <= RCL_HOLD;
				end
				RCL_HOLD: begin
					if (hold_r == 8'h00) begin
						st_r <= RCL_REL;
					end else begin
						hold_r <= hold_r - 8'h01;
					end
				end
				RCL_REL: begin
					core_rst_o <= 1'b0;
					st_r <= RCL_RUN;
				end
				default: st_r <= RCL_RUN;
			endcase
		end
	end
	// ********************
	// Cause flags
	// ********************
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			wcf_r <= 1'b0;
			vsf_r <= 1'b0;
			lvf_r <= 1'b0;
		end else begin
			if (st_r == RCL_RUN && vs_bad) begin
				vsf_r <= 1'b1;
			end else if (wr_en && paddr_i == RCL_CAUSE_OFS &&
				!pwdata_i[RCL_VSF_BIT]) begin
				vsf_r <= 1'b0;
			end
			if (lv_ev) begin
				lvf_r <= 1'b1;
			end else if (wr_en && paddr_i == RCL_CAUSE_OFS &&
				!pwdata_i[RCL_LVF_BIT]) begin
				lvf_r <= 1'b0;
			end
			if (wr_en && paddr_i == RCL_CAUSE_OFS &&
				!pwdata_i[RCL_WCF_BIT]) begin
				wcf_r <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			exp_r <= 1'b0;
			pdf_r <= 1'b0;
		end else if (st_r == RCL_RUN && wdt_exp) begin
			exp_r <= 1'b1;
			if (sleep_i) begin
				pdf_r <= 1'b1;
			end
		end
	end
	// ********************
	// Core state per cause
	// ********************
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			pc_low_o <= 8'h00;
			stack_index_o <= RCL_STK_TOP;
			int_en_o <= 8'h00;
			timer_on_o <= 4'h0;
			vsel_r <= RCL_VSEL_POR;
			wlimit_r <= '1;
		end else if (st_r == RCL_REC) begin
			pc_low_o <= 8'h00;
			stack_index_o <= RCL_STK_TOP;
			if (cause_r == RCL_C_WRUN) begin
				int_en_o <= 8'h00;
				timer_on_o <= 4'h0;
				if (vs_bad || by_wdt_r) begin
					vsel_r <= RCL_VSEL_POR;
				end
			end
		end else if (wr_en) begin
			case (paddr_i)
				RCL_VSEL_OFS: vsel_r <= pwdata_i[7:0];
				RCL_CTRL_OFS: begin
					int_en_o <= pwdata_i[15:8];
					timer_on_o <= pwdata_i[3:0];
				end
				RCL_CPU_OFS: wlimit_r <= pwdata_i[WDT_W+11:12];
				default: pc_low_o <= pc_low_o;
			endcase
		end
	end
	// ********************
	// Port data path
	// ********************
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			pdata_r <= RCL_PORT_POR;
			pdir_r <= RCL_PORT_POR;
		end else if (st_r == RCL_REC && cause_r == RCL_C_WRUN) begin
			pdata_r <= RCL_PORT_POR;
			pdir_r <= RCL_PORT_POR;
		end else if (wr_en && paddr_i == RCL_PDATA_OFS) begin
			pdata_r <= pwdata_i[7:0];
		end else if (wr_en && paddr_i == RCL_PDIR_OFS) begin
			pdir_r <= pwdata_i[7:0];
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			pin_o <= RCL_PORT_POR;
			pin_oe_n_o <= RCL_PORT_POR;
		end else begin
			pin_o <= pdata_r;
			pin_oe_n_o <= pdir_r;
		end
	end
	// ********************
	// Interrupts
	// ********************
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			irqs_r <= 3'h0;
			irqm_r <= 3'h0;
			irq_o <= 1'b0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (wr_en && paddr_i == RCL_IRQS_OFS && pwdata_i[i]) begin
					irqs_r[i] <= 1'b0;
				end
			end
			if (st_r == RCL_RUN && wdt_exp) begin
				irqs_r[RCL_IRQ_WDT] <= 1'b1;
			end
			if (lv_ev) begin
				irqs_r[RCL_IRQ_LV] <= 1'b1;
			end
			if (st_r == RCL_RUN && vs_bad) begin
				irqs_r[RCL_IRQ_VS] <= 1'b1;
			end
			if (wr_en && paddr_i == RCL_IRQM_OFS) begin
				irqm_r <= pwdata_i[2:0];
			end
			irq_o <= |(irqs_r & irqm_r);
		end
	end
	// ********************
	// Checks
	// ********************
	vsf_set_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		(st_r == RCL_RUN && vs_bad) |=> vsf_r)
		else $error("fault flag not set");
	vsf_keep_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		(vsf_r && !wr_en) |=> vsf_r)
		else $error("fault flag cleared by hardware");
	exp_run_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		(st_r == RCL_RUN && wdt_exp && !sleep_i) |=> exp_r && core_rst_o)
		else $error("running expiry not handled");
	exp_slp_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		(st_r == RCL_RUN && wdt_exp && sleep_i) |=>
		exp_r && pdf_r && !core_rst_o ##1 pc_low_o == 8'h00)
		else $error("sleep expiry not handled");
	pdf_keep_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		(!sleep_i) |=> pdf_r == $past(pdf_r))
		else $error("powerdown flag changed");
	wdt_clr_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		(st_r == RCL_REL) |=> ##2 !wdt_exp)
		else $error("watchdog not cleared");
	por_state_a: assert property (
		@(posedge clk_sys_i)
		$fell(srst_i) |-> int_en_o == 8'h00 && timer_on_o == 4'h0 &&
		pin_oe_n_o == 8'hFF && stack_index_o == RCL_STK_TOP)
		else $error("power-on state wrong");
	latch_hold_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		!(wr_en && paddr_i == RCL_PDATA_OFS) && st_r == RCL_RUN |=>
		pdata_r == $past(pdata_r))
		else $error("output latch changed");
	lv_set_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		lv_ev |=> lvf_r)
		else $error("low voltage flag not set");
	release_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		(st_r == RCL_REL) |=> !core_rst_o && st_r == RCL_RUN)
		else $error("release out of step");
	wrun_state_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		(st_r == RCL_REC && cause_r == RCL_C_WRUN) |=>
		int_en_o == 8'h00 && timer_on_o == 4'h0 &&
		pdir_r == RCL_PORT_POR)
		else $error("running reset state wrong");
	wdt_vsel_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		(st_r == RCL_REC && cause_r == RCL_C_WRUN && by_wdt_r) |=>
		vsel_r == RCL_VSEL_POR)
		else $error("select not reloaded");
	slp_keep_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		(st_r == RCL_REC && cause_r == RCL_C_WSLP && !wr_en) |=>
		stack_index_o == RCL_STK_TOP && int_en_o == $past(int_en_o) &&
		pdir_r == $past(pdir_r))
		else $error("sleep expiry changed kept state");
	lv_keep_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		(st_r == RCL_RUN && lv_ev && !wdt_exp) |=>
		exp_r == $past(exp_r) && pdf_r == $past(pdf_r))
		else $error("supply reset changed expiry flags");
	pin_follow_a: assert property (
		@(posedge clk_sys_i) disable iff (srst_i)
		1'b1 |=> pin_o == $past(pdata_r) && pin_oe_n_o == $past(pdir_r))
		else $error("pin drive not from latch");
endmodule
`default_nettype wire

// >>> design/rcl_wdt_cnt.sv
// Watchdog counter: cleared by the sequencer, counts otherwise.
// Assumes the reset and clear inputs are synchronous to clk_sys_i.
`timescale 1ns/10ps
`default_nettype none
module rcl_wdt_cnt #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// Control
	input wire logic clr_i,
	input wire logic [WIDTH-1:0] limit_i,
	// Status
	output logic expire_o
);
	logic [WIDTH-1:0] cnt_r;
	// ********************
	// Counter
	// ********************
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || clr_i) begin
			cnt_r <= '0;
			expire_o <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			expire_o <= (cnt_r == limit_i);
		end
	end
endmodule
`default_nettype wire

// >>> sim/rcl_top_tb.sv
// Self-checking bench for the reset-condition logic block.
// Assumes rcl_top with APB at byte addresses and pkg constants.
`timescale 1ns/10ps
`default_nettype none
module rcl_top_tb
	import rcl_pkg::*;
;
	// ****************
	// Signals
	// ****************
	logic clk_sys_i, srst_i, psel_i, penable_i, pwrite_i;
	logic [7:0] paddr_i, pin_i, pin_o, pin_oe_n_o, pc_low_o, int_en_o;
	logic [31:0] pwdata_i, prdata_o;
	logic pready_o, pslverr_o, sleep_i, lv_drop_i, core_rst_o, irq_o;
	logic [3:0] stack_index_o, timer_on_o;
	logic [7:0] pd;
	logic [31:0] exp_q[$], msk_q[$];
	int num_errors = 0;
	int cmp_count = 0;
	logic [7:0] codes[4] = '{RCL_VSEL_C1, RCL_VSEL_C2, RCL_VSEL_C3,
		RCL_VSEL_POR};
	rcl_top dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .sleep_i(sleep_i), .lv_drop_i(lv_drop_i),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
		.core_rst_o(core_rst_o), .pc_low_o(pc_low_o),
		.stack_index_o(stack_index_o), .int_en_o(int_en_o),
		.timer_on_o(timer_on_o), .irq_o(irq_o));
	// ****************
	// Tasks
	// ****************
	task conclude;
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (n >= 50) begin
			num_errors++;
			conclude();
		end
		@(posedge clk_sys_i);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFFFFFF);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		apb(1'b0, a, 32'h0);
	endtask
	task wt(input logic v, input logic irq);
		int n;
		n = 0;
		while (((irq ? irq_o : core_rst_o) !== v) && n < 3000) begin
			@(posedge clk_sys_i);
			n++;
		end
		if (n >= 3000) begin
			num_errors++;
			conclude();
		end
	endtask
	// ****************
	// Monitor
	// ****************
	always @(posedge clk_sys_i) begin
		if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
			if (exp_q.size() == 0)
				num_errors++;
			else
				chk(prdata_o & msk_q.pop_front(), exp_q.pop_front());
			chk(32'(pslverr_o), 32'(paddr_i > RCL_CPU_OFS));
		end
	end
	// ****************
	// Stimulus
	// ****************
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		{psel_i, penable_i, pwrite_i, sleep_i, lv_drop_i} = 5'h00;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		pin_i = 8'h00;
		srst_i = 1'b1;
		void'($urandom(84));
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		wt(1'b0, 1'b0);
		chk(32'(pin_oe_n_o), 32'hFF);
		chk(32'(int_en_o), 32'h0);
		chk(32'(timer_on_o), 32'h0);
		rd(RCL_CAUSE_OFS, 32'h0, 32'h3);
		rd(RCL_VSEL_OFS, 32'(RCL_VSEL_POR));
		rd(RCL_STAT_OFS, 32'h0);
		rd(RCL_PDATA_OFS, 32'(RCL_PORT_POR));
		rd(RCL_PDIR_OFS, 32'(RCL_PORT_POR));
		rd(RCL_CPU_OFS, {20'h0, RCL_STK_TOP, 8'h00});
		rd(8'h80, 32'h0);
		pd = 8'($urandom);
		wr(RCL_PDIR_OFS, 32'h0F);
		wr(RCL_PDATA_OFS, {24'h0, pd});
		pin_i <= ~pd;
		chk(32'(pin_oe_n_o), 32'h0F);
		rd(RCL_PIN_OFS, {24'h0, ~pd});
		pin_i <= pd ^ 8'h5A;
		rd(RCL_PIN_OFS, {24'h0, pd ^ 8'h5A});
		chk(32'(pin_o), 32'(pd));
		wr(RCL_CTRL_OFS, 32'h5A03);
		chk(32'(int_en_o), 32'h5A);
		wr(RCL_VSEL_OFS, 32'(RCL_VSEL_C1));
		wr(RCL_CPU_OFS, 32'h00040000);
		wt(1'b1, 1'b0);
		wt(1'b0, 1'b0);
		rd(RCL_STAT_OFS, 32'h20);
		rd(RCL_CTRL_OFS, 32'h0);
		rd(RCL_PDATA_OFS, 32'(RCL_PORT_POR));
		rd(RCL_VSEL_OFS, 32'(RCL_VSEL_POR));
		wr(RCL_CPU_OFS, 32'h00040000);
		wt(1'b1, 1'b0);
		wt(1'b0, 1'b0);
		wr(RCL_CPU_OFS, 32'h0FFFF000);
		wr(RCL_IRQS_OFS, 32'h7);
		wr(RCL_IRQM_OFS, 32'h7);
		wr(RCL_CTRL_OFS, 32'h5A03);
		wr(RCL_PDATA_OFS, {24'h0, pd});
		sleep_i <= 1'b1;
		wr(RCL_CPU_OFS, 32'h00040000);
		wt(1'b1, 1'b1);
		sleep_i <= 1'b0;
		wr(RCL_CPU_OFS, 32'h0FFFF000);
		rd(RCL_STAT_OFS, 32'h30);
		rd(RCL_CTRL_OFS, 32'h5A03);
		rd(RCL_CPU_OFS, 32'h0);
		chk(32'(pin_o), 32'(pd));
		wr(RCL_IRQS_OFS, 32'h7);
		wr(RCL_VSEL_OFS, 32'(RCL_VSEL_C2));
		lv_drop_i <= 1'b1;
		wt(1'b1, 1'b0);
		lv_drop_i <= 1'b0;
		wt(1'b0, 1'b0);
		rd(RCL_CAUSE_OFS, 32'h4, 32'h4);
		rd(RCL_VSEL_OFS, 32'(RCL_VSEL_C2));
		rd(RCL_STAT_OFS, 32'h30);
		wr(RCL_IRQM_OFS, 32'h5);
		repeat (2) @(posedge clk_sys_i);
		chk(32'(irq_o), 32'h0);
		wr(RCL_IRQM_OFS, 32'h7);
		wt(1'b1, 1'b1);
		wr(RCL_IRQS_OFS, 32'h2);
		repeat (2) @(posedge clk_sys_i);
		chk(32'(irq_o), 32'h0);
		wr(RCL_CAUSE_OFS, 32'h0);
		rd(RCL_CAUSE_OFS, 32'h0, 32'h4);
		foreach (codes[i]) begin
			wr(RCL_VSEL_OFS, 32'(codes[i]));
			rd(RCL_VSEL_OFS, 32'(codes[i]));
		end
		rd(RCL_CAUSE_OFS, 32'h0, 32'h2);
		wr(RCL_VSEL_OFS, 32'h12);
		wt(1'b1, 1'b0);
		wt(1'b0, 1'b0);
		rd(RCL_CAUSE_OFS, 32'h2, 32'h2);
		rd(RCL_VSEL_OFS, 32'(RCL_VSEL_POR));
		wr(RCL_CAUSE_OFS, 32'hFF);
		rd(RCL_CAUSE_OFS, 32'h2, 32'h2);
		wr(RCL_CAUSE_OFS, 32'h0);
		rd(RCL_CAUSE_OFS, 32'h0, 32'h2);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		wt(1'b0, 1'b0);
		rd(RCL_STAT_OFS, 32'h0);
		chk(32'(pin_oe_n_o), 32'hFF);
		chk(32'(exp_q.size()), 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
